/* File: sss_sequencer.v */
`timescale 1ns/1ps
`include "sss_defines.vh"
module sss_sequencer #(
   parameter POLL_CYC = `SSS_POLL_CYC,
   parameter QUIET_CYC = `SSS_QUIET_CYC,
   parameter NAV_SPACING_CYC = `SSS_NAV_SPACING_CYC,
   parameter NAV_MIN_PERIOD = `SSS_NAV_MIN_PERIOD_CYC,
   parameter NAV_MAX_PERIOD = `SSS_NAV_MAX_PERIOD_CYC
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire operation_launch_bit,
   input wire direction_report_mode,
   input wire [7:0] start_col,
   input wire [7:0] stop_col,
   input wire pixel_2bit,
   input wire [31:0] poll_period,
   input wire [31:0] nav_period,
   input wire host_bus_active,
   input wire finger_present,
   input wire [3:0] adc_value,
   input wire [2:0] nav_direction,
   output reg array_power,
   output reg core_clk_en,
   output reg [7:0] col_select,
   output reg [3:0] row_select,
   output reg sample_strobe,
   output reg [7:0] out_byte,
   output reg out_valid,
   output reg busy
);
   // ==========================================
   // States
   localparam ST_IDLE = 3'h0;
   localparam ST_POLL = 3'h1;
   localparam ST_SCAN = 3'h2;
   localparam ST_NAV_SAMPLE = 3'h3;
   localparam ST_NAV_MSG_LO = 3'h4;
   localparam ST_NAV_MSG_HI = 3'h5;
   localparam ST_NAV_SLEEP = 3'h6;

   reg [2:0] state;
   reg [31:0] timer;
   reg [31:0] quiet_cnt;
   reg [3:0] nav_cnt;
   reg [3:0] pix_lo;
   reg pix_half;
   reg nav_seen;
   reg [2:0] nav_dir_hold;
   reg [31:0] space_cnt;
   wire quiet = (quiet_cnt >= QUIET_CYC);
   wire [31:0] poll_eff = (poll_period == 32'h0) ? POLL_CYC : poll_period;
   wire [31:0] nav_clamped = (nav_period < NAV_MIN_PERIOD) ? NAV_MIN_PERIOD :
                             (nav_period > NAV_MAX_PERIOD) ? NAV_MAX_PERIOD : nav_period;
   wire [7:0] first_col = (start_col > stop_col) ? stop_col : start_col;
   wire [7:0] last_col = (stop_col > `SSS_LAST_COL) ? `SSS_LAST_COL : stop_col;
   wire [3:0] pix = pixel_2bit ? {2'h0, adc_value[3:2]} : adc_value;

   // ==========================================
   // Host bus inactivity
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         quiet_cnt <= 32'h0;
      end else if (host_bus_active) begin
         quiet_cnt <= 32'h0;
      end else if (!quiet) begin
         quiet_cnt <= quiet_cnt + 32'h1;
      end
   end

   // ==========================================
   // Sequencer
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         timer <= 32'h0;
         nav_cnt <= 4'h0;
         pix_lo <= 4'h0;
         pix_half <= 1'b0;
         nav_seen <= 1'b0;
         nav_dir_hold <= `SSS_DIR_NONE;
         space_cnt <= 32'h0;
         array_power <= 1'b0;
         core_clk_en <= 1'b0;
         col_select <= 8'h0;
         row_select <= 4'h0;
         sample_strobe <= 1'b0;
         out_byte <= 8'h0;
         out_valid <= 1'b0;
         busy <= 1'b0;
      end else begin
         out_valid <= 1'b0;
         sample_strobe <= 1'b0;
         if (!operation_launch_bit) begin
            state <= ST_IDLE;
            array_power <= 1'b0;
            core_clk_en <= 1'b0;
            busy <= 1'b0;
            timer <= 32'h0;
         end else begin
            busy <= 1'b1;
            case (state)
               ST_IDLE: begin
                  timer <= 32'h0;
                  state <= direction_report_mode ? ST_NAV_SAMPLE : ST_POLL;
                  nav_cnt <= 4'h0;
                  nav_seen <= 1'b0;
                  space_cnt <= 32'h0;
               end
               ST_POLL: begin
                  if (quiet) begin
                     array_power <= 1'b0;
                     core_clk_en <= 1'b0;
                  end
                  if (timer >= poll_eff - 32'h1) begin
                     timer <= 32'h0;
                     sample_strobe <= 1'b1;
                     if (finger_present) begin
                        state <= ST_SCAN;
                        array_power <= 1'b1;
                        core_clk_en <= 1'b1;
                        col_select <= first_col;
                        row_select <= 4'h0;
                        pix_half <= 1'b0;
                     end
                  end else begin
                     timer <= timer + 32'h1;
                  end
               end
               ST_SCAN: begin
                  sample_strobe <= 1'b1;
                  if (!pix_half) begin
                     pix_lo <= pix;
                     pix_half <= 1'b1;
                  end else begin
                     out_byte <= {pix, pix_lo};
                     out_valid <= 1'b1;
                     pix_half <= 1'b0;
                  end
                  if (row_select == 4'hf) begin
                     row_select <= 4'h0;
                     if (col_select >= last_col) begin
                        col_select <= first_col;
                        if (!finger_present) begin
                           state <= ST_POLL;
                           array_power <= 1'b0;
                           timer <= 32'h0;
                        end
                     end else begin
                        col_select <= col_select + 8'h1;
                     end
                  end else begin
                     row_select <= row_select + 4'h1;
                  end
               end
               ST_NAV_SAMPLE: begin
                  array_power <= 1'b1;
                  core_clk_en <= 1'b1;
                  col_select <= `SSS_CENTRE_COL;
                  timer <= timer + 32'h1;
                  if (space_cnt >= NAV_SPACING_CYC - 1) begin
                     space_cnt <= 32'h0;
                     sample_strobe <= 1'b1;
                     nav_seen <= nav_seen | finger_present;
                     nav_dir_hold <= nav_direction;
                     if (nav_cnt == `SSS_NAV_SAMPLES - 1) begin
                        nav_cnt <= 4'h0;
                        state <= ST_NAV_MSG_LO;
                     end else begin
                        nav_cnt <= nav_cnt + 4'h1;
                     end
                  end else begin
                     space_cnt <= space_cnt + 32'h1;
                  end
               end
               ST_NAV_MSG_LO: begin
                  out_byte <= {5'h0, nav_dir_hold};
                  out_valid <= 1'b1;
                  timer <= timer + 32'h1;
                  state <= ST_NAV_MSG_HI;
               end
               ST_NAV_MSG_HI: begin
                  out_byte <= {7'h0, nav_seen};
                  out_valid <= 1'b1;
                  array_power <= 1'b0;
                  timer <= timer + 32'h1;
                  nav_seen <= 1'b0;
                  state <= ST_NAV_SLEEP;
               end
               ST_NAV_SLEEP: begin
                  if (quiet) begin
                     core_clk_en <= 1'b0;
                  end
                  if (timer >= nav_clamped - 32'h1) begin
                     timer <= 32'h0;
                     space_cnt <= 32'h0;
                     state <= ST_NAV_SAMPLE;
                  end else begin
                     timer <= timer + 32'h1;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule

/* File: sss_defines.vh */
`ifndef SSS_DEFINES_VH
`define SSS_DEFINES_VH
// ==========================================
// Array geometry
`define SSS_NUM_COLS 192
`define SSS_NUM_ROWS 16
`define SSS_NARROW_FIRST 8'h20
`define SSS_NARROW_LAST 8'h9f
`define SSS_LAST_COL 8'hbf
`define SSS_CENTRE_COL 8'h60
// ==========================================
// Timing, clock 250 MHz
`define SSS_CLK_MHZ 250
`define SSS_POLL_MS 62
`define SSS_POLL_CYC (`SSS_POLL_MS * 1000 * `SSS_CLK_MHZ)
`define SSS_QUIET_US 200
`define SSS_QUIET_CYC (`SSS_QUIET_US * `SSS_CLK_MHZ)
`define SSS_NAV_SPACING_US 100
`define SSS_NAV_SPACING_CYC (`SSS_NAV_SPACING_US * `SSS_CLK_MHZ)
`define SSS_NAV_SAMPLES 10
`define SSS_NAV_FAST_HZ 100
`define SSS_NAV_SLOW_HZ 26
`define SSS_NAV_MIN_PERIOD_CYC (`SSS_CLK_MHZ * 1000000 / `SSS_NAV_FAST_HZ)
`define SSS_NAV_MAX_PERIOD_CYC (`SSS_CLK_MHZ * 1000000 / `SSS_NAV_SLOW_HZ)
// ==========================================
// Launch bit position in control byte 80h
`define SSS_CTRL_ADDR 8'h80
`define SSS_LAUNCH_BIT 2
// ==========================================
// Direction codes
`define SSS_DIR_NONE 3'h0
`define SSS_DIR_LEFT 3'h1
`define SSS_DIR_RIGHT 3'h2
`define SSS_DIR_UP 3'h3
`define SSS_DIR_DOWN 3'h4
`endif

/* File: sss_host_model.sv */
`timescale 1ns/1ps
// ==========================================
// Host side: bus traffic and finger on pad
module sss_host_model (
   input wire sys_clk,
   input wire talk,
   input wire touch,
   output reg host_bus_active = 1'b0,
   output reg finger_present = 1'b0
);
   always @(posedge sys_clk) begin
      host_bus_active <= #1 talk;
      finger_present <= #1 touch;
   end
endmodule

/* File: sss_checker.sv */
`timescale 1ns/1ps
// ==========================================
// Port checks
module sss_checker (
   input wire sys_clk,
   input wire sys_rst,
   input wire operation_launch_bit,
   input wire direction_report_mode,
   input wire [7:0] start_col,
   input wire [7:0] stop_col,
   input wire array_power,
   input wire core_clk_en,
   input wire [7:0] col_select,
   input wire sample_strobe,
   input wire out_valid,
   input wire busy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence sq_off;
      !operation_launch_bit [*3];
   endsequence
   sequence sq_img;
      !direction_report_mode && array_power;
   endsequence
   chk_off_unpowered: assert property (sq_off |-> !array_power) else $error("array on while stopped");
   chk_off_quiet: assert property (sq_off |-> !out_valid) else $error("output while stopped");
   chk_off_no_sample: assert property (sq_off |-> !sample_strobe) else $error("sampling while stopped");
   chk_off_not_busy: assert property (sq_off |-> !busy) else $error("busy while stopped");
   chk_start_needs_launch: assert property ($rose(busy) |-> $past(operation_launch_bit)) else $error("start unlaunched");
   chk_power_clocked: assert property (array_power |-> core_clk_en) else $error("array on, clock gated");
   chk_byte_spacing: assert property ((sq_img and out_valid) |=> !out_valid) else $error("pixel bytes too close");
   chk_col_window: assert property ((sq_img and sample_strobe) |-> col_select >= start_col && col_select <= stop_col)
      else $error("column outside window");
endmodule
bind sss_sequencer sss_checker u_sss_checker (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .operation_launch_bit(operation_launch_bit), .direction_report_mode(direction_report_mode),
   .start_col(start_col), .stop_col(stop_col), .array_power(array_power), .core_clk_en(core_clk_en),
   .col_select(col_select), .sample_strobe(sample_strobe), .out_valid(out_valid), .busy(busy));

/* File: slide_sensor_operation_sequencer_tb_top.sv */
`timescale 1ns/1ps
module slide_sensor_operation_sequencer_tb_top;
   reg sys_clk = 0, sys_rst = 1, go = 0, mode = 0, p2 = 0, talk = 0, touch = 0;
   reg [7:0] c0 = 0, c1 = 0;
   reg [31:0] poll = 0, navp = 200;
   reg [3:0] adc = 0;
   reg [2:0] dir = 0;
   wire act, fing, pwr, clk_en, strobe, vld, busy;
   wire [7:0] col, ob;
   wire [3:0] row;
   integer n_errors = 0, checks_done = 0, i, k, gated;
   sss_sequencer #(.POLL_CYC(20), .QUIET_CYC(40), .NAV_SPACING_CYC(4), .NAV_MIN_PERIOD(60), .NAV_MAX_PERIOD(200))
   u_sss_sequencer (.sys_clk(sys_clk), .sys_rst(sys_rst), .operation_launch_bit(go), .direction_report_mode(mode),
      .start_col(c0), .stop_col(c1), .pixel_2bit(p2), .poll_period(poll), .nav_period(navp),
      .host_bus_active(act), .finger_present(fing), .adc_value(adc), .nav_direction(dir), .array_power(pwr),
      .core_clk_en(clk_en), .col_select(col), .row_select(row), .sample_strobe(strobe), .out_byte(ob),
      .out_valid(vld), .busy(busy));
   sss_host_model u_sss_host_model (.sys_clk(sys_clk), .talk(talk), .touch(touch), .host_bus_active(act),
      .finger_present(fing));
   initial forever #2 sys_clk = ~sys_clk;
   task check(input [7:0] seen, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("errors %0d checks %0d", n_errors, checks_done);
         if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge sys_clk);
         #1;
      end
   endtask
   task wait_vld;
      begin
         i = 0;
         tick(1);
         while (vld !== 1'b1 && i < 2000) begin
            tick(1);
            i = i + 1;
         end
         check(vld, 1);
      end
   endtask
   function [7:0] pix_byte(input [3:0] a, input b);
      pix_byte = b ? {2'h0, a[3:2], 2'h0, a[3:2]} : {a, a};
   endfunction
   function [7:0] nav_clamp(input [31:0] p);
      nav_clamp = (p < 32'h3c) ? 8'h3c : (p > 32'hc8) ? 8'hc8 : p[7:0];
   endfunction
   // ==========================================
   // Imaging run over a two-column window
   task img_run(input [7:0] s, input b, input [7:0] p);
      begin
         c0 = s;
         c1 = s + 8'h01;
         adc = $urandom;
         p2 = b;
         poll = p;
         talk = 1;
         touch = 1;
         go = 1;
         wait_vld;
         check(i, (p == 8'h00) ? 8'h16 : p + 8'h02);
         check(ob, pix_byte(adc, b));
         check(col >= c0 && col <= c1, 1);
         touch = 0;
         tick(300);
         check(pwr, 0);
         go = 0;
         tick(3);
         check(busy, 0);
      end
   endtask
   initial begin
      #200000;
      n_errors = n_errors + 1;
      give_verdict;
   end
   initial begin
      k = $urandom(13);
      tick(5);
      sys_rst = 0;
      tick(50);
      check(pwr, 0);
      check(busy, 0);
      img_run(8'h00, 0, 8'h00);
      img_run(8'hbe, 0, 8'h02);
      img_run(8'h20, 1, $urandom_range(2, 40));
      for (k = 0; k < 3; k = k + 1) img_run($urandom_range(0, 190), $urandom, $urandom_range(2, 40));
      // ==========================================
      // Direction reports
      mode = 1;
      talk = 0;
      touch = 1;
      dir = $urandom_range(1, 4);
      navp = $urandom_range(160, 300);
      go = 1;
      wait_vld;
      check(i, 8'h29);
      check(ob, {5'h00, dir});
      wait_vld;
      check(ob, 8'h01);
      gated = 0;
      for (k = 0; k < 150; k = k + 1) begin
         tick(1);
         if (clk_en === 1'b0) gated = 1;
      end
      check(gated, 1);
      wait_vld;
      check(i + 151, nav_clamp(navp) - 8'h01);
      go = 0;
      tick(3);
      check(pwr, 0);
      give_verdict;
   end
endmodule
